// *** hdl/pwm16_pkg.sv ***
// package: register map, control fields and reset values of the pwm block
package pwm16_pkg;
  localparam logic [15:0] WAVEFORM_CONTROL_ADDR = 16'hA028;
  localparam logic [15:0] PERIOD_HIGH_ADDR = 16'hA029;
  localparam logic [15:0] PERIOD_LOW_ADDR = 16'hA02A;
  localparam logic [15:0] DUTY_HIGH_ADDR = 16'hA02B;
  localparam logic [15:0] DUTY_LOW_ADDR = 16'hA02C;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [2:0] PRESCALE_RESET = 3'h0;
  localparam int MODULE_ENABLE_BIT = 7;
  localparam int PRESCALE_HI_BIT = 6;
  localparam int PRESCALE_LO_BIT = 4;
  localparam int IDLE_LEVEL_BIT = 3;
  localparam int IRQ_ENABLE_BIT = 2;
  localparam int OUTPUT_INVERT_BIT = 1;
  localparam int RELOAD_FLAG_BIT = 0;

  // software-writable control fields
  typedef struct packed {
    logic module_enable;
    logic [2:0] prescale_select;
    logic idle_level;
    logic irq_enable;
    logic output_invert;
  } ctrl_t;

  localparam ctrl_t CTRL_RESET = '{1'b0, 3'h0, 1'b0, 1'b0, 1'b0};

  // register port request
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;
endpackage

// *** hdl/pwm16.sv ***
// 16-bit pwm generator with prescaler, staged period/duty and reload flag
//
// Functional notes
// - counter ticks at system clock divided by prescale_select plus one.
// - counter returns to zero on the tick after reaching period_value.
// - normal polarity: low below duty, high at or above duty.
// - output_invert set inverts the waveform while enabled; the idle level is output uninverted.
// - active duty loads from shadow only at counter reload.
// - duty bytes and period low staged; committed on period high write.
// - reload_flag sets on every reload to zero.
// - interrupt request is reload_flag gated by irq_enable.
// - writing one clears reload_flag; zero leaves it; set wins.
// - request drives shared_irq_line, shared with converter interrupt.
// - disabled: generation stops, output held at idle level.
// - period and duty each appear as high and low byte registers.
`timescale 1ns/100ps
module pwm16
  import pwm16_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // register port
  input wire logic [15:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // waveform and interrupt
  output logic waveform_out_o,
  output logic shared_irq_line_o
);

  ////////////////////////////////////////////////////////////////////////
  reg_req_t req;
  ctrl_t ctrl_q, ctrl_d;
  logic flag_q, flag_d;
  logic [15:0] period_q, period_d; // committed period
  logic [15:0] duty_sh_q, duty_sh_d; // committed shadow duty
  logic [15:0] duty_act_q, duty_act_d; // duty in use by comparator
  logic [7:0] per_lo_tmp_q, per_lo_tmp_d;
  logic [7:0] duty_hi_tmp_q, duty_hi_tmp_d;
  logic [7:0] duty_lo_tmp_q, duty_lo_tmp_d;
  logic [2:0] pre_q, pre_d;
  logic [15:0] cnt_q, cnt_d;
  logic out_q, out_d;
  logic [7:0] rdata_q, rdata_d;
  logic tick, reload;

  assign req = '{addr_i, wdata_i, wr_i, rd_i};

  ////////////////////////////////////////////////////////////////////////
  // register writes, staging and flag
  always_comb begin
    ctrl_d = ctrl_q;
    flag_d = flag_q;
    period_d = period_q;
    duty_sh_d = duty_sh_q;
    per_lo_tmp_d = per_lo_tmp_q;
    duty_hi_tmp_d = duty_hi_tmp_q;
    duty_lo_tmp_d = duty_lo_tmp_q;
    if (req.wr) begin
      case (req.addr)
        WAVEFORM_CONTROL_ADDR: begin
          ctrl_d.module_enable = req.wdata[MODULE_ENABLE_BIT];
          ctrl_d.prescale_select =
            req.wdata[PRESCALE_HI_BIT:PRESCALE_LO_BIT];
          ctrl_d.idle_level = req.wdata[IDLE_LEVEL_BIT];
          ctrl_d.irq_enable = req.wdata[IRQ_ENABLE_BIT];
          ctrl_d.output_invert = req.wdata[OUTPUT_INVERT_BIT];
          if (req.wdata[RELOAD_FLAG_BIT]) begin
            flag_d = 1'b0;
          end
        end
        PERIOD_LOW_ADDR: per_lo_tmp_d = req.wdata;
        DUTY_HIGH_ADDR: duty_hi_tmp_d = req.wdata;
        DUTY_LOW_ADDR: duty_lo_tmp_d = req.wdata;
        PERIOD_HIGH_ADDR: begin
          // commit everything staged together
          period_d = {req.wdata, per_lo_tmp_q};
          duty_sh_d = {duty_hi_tmp_q, duty_lo_tmp_q};
        end
        default: ;
      endcase
    end
    if (reload) begin
      flag_d = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_q <= CTRL_RESET;
      flag_q <= 1'b0;
      period_q <= WORD_RESET;
      duty_sh_q <= WORD_RESET;
      per_lo_tmp_q <= BYTE_RESET;
      duty_hi_tmp_q <= BYTE_RESET;
      duty_lo_tmp_q <= BYTE_RESET;
    end else begin
      ctrl_q <= ctrl_d;
      flag_q <= flag_d;
      period_q <= period_d;
      duty_sh_q <= duty_sh_d;
      per_lo_tmp_q <= per_lo_tmp_d;
      duty_hi_tmp_q <= duty_hi_tmp_d;
      duty_lo_tmp_q <= duty_lo_tmp_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // prescaler, counter, active duty and output
  assign tick = ctrl_q.module_enable &&
                (pre_q == ctrl_q.prescale_select);
  assign reload = tick && (cnt_q == period_q);

  always_comb begin
    pre_d = pre_q;
    cnt_d = cnt_q;
    duty_act_d = duty_act_q;
    if (!ctrl_q.module_enable) begin
      pre_d = PRESCALE_RESET;
      cnt_d = WORD_RESET;
    end else begin
      if (tick) begin
        pre_d = PRESCALE_RESET;
      end else begin
        pre_d = pre_q + 3'h1;
      end
      if (reload) begin
        cnt_d = WORD_RESET;
        duty_act_d = duty_sh_q;
      end else if (tick) begin
        cnt_d = cnt_q + 16'h0001;
      end
    end
    if (!ctrl_q.module_enable) begin
      out_d = ctrl_q.idle_level;
    end else begin
      out_d = (cnt_q >= duty_act_q) ^ ctrl_q.output_invert;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pre_q <= PRESCALE_RESET;
      cnt_q <= WORD_RESET;
      duty_act_q <= WORD_RESET;
      out_q <= 1'b0;
    end else begin
      pre_q <= pre_d;
      cnt_q <= cnt_d;
      duty_act_q <= duty_act_d;
      out_q <= out_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read data, one cycle after the read strobe
  always_comb begin
    rdata_d = BYTE_RESET;
    if (req.rd) begin
      case (req.addr)
        WAVEFORM_CONTROL_ADDR: rdata_d = {ctrl_q.module_enable,
          ctrl_q.prescale_select, ctrl_q.idle_level, ctrl_q.irq_enable,
          ctrl_q.output_invert, flag_q};
        PERIOD_HIGH_ADDR: rdata_d = period_q[15:8];
        PERIOD_LOW_ADDR: rdata_d = per_lo_tmp_q;
        DUTY_HIGH_ADDR: rdata_d = duty_hi_tmp_q;
        DUTY_LOW_ADDR: rdata_d = duty_lo_tmp_q;
        default: rdata_d = BYTE_RESET;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_q <= BYTE_RESET;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs
  assign rdata_o = rdata_q;
  assign waveform_out_o = out_q;
  assign shared_irq_line_o = flag_q & ctrl_q.irq_enable;

  ////////////////////////////////////////////////////////////////////////
  // checks
  reload_sets_flag_a: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    reload |=> flag_q)
    else $error("reload did not set flag");

  flag_clear_a: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (req.wr && req.addr == WAVEFORM_CONTROL_ADDR &&
     req.wdata[RELOAD_FLAG_BIT] && !reload) |=> !flag_q)
    else $error("flag not cleared by write of one");

  flag_hold_a: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (flag_q && !(req.wr && req.addr == WAVEFORM_CONTROL_ADDR &&
     req.wdata[RELOAD_FLAG_BIT])) |=> flag_q)
    else $error("flag lost without clear");

  irq_gate_a: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    shared_irq_line_o == (flag_q && ctrl_q.irq_enable))
    else $error("irq not gated by enable");

  counter_wrap_a: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    reload |=> cnt_q == 16'h0000)
    else $error("counter did not wrap to zero");

  // a period commit may shrink the bound, so that edge is left out
  counter_bound_a: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (ctrl_q.module_enable && $stable(period_q) && cnt_q <= period_q &&
     !(req.wr && req.addr == PERIOD_HIGH_ADDR)) |=> cnt_q <= period_q)
    else $error("counter passed period");

  prescale_step_a: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (ctrl_q.module_enable && !tick && $stable(ctrl_q)) |=>
    $stable(cnt_q))
    else $error("counter moved without tick");

  disabled_out_a: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    !ctrl_q.module_enable |=> waveform_out_o == $past(ctrl_q.idle_level)
    && cnt_q == 16'h0000)
    else $error("disabled output not idle level");

  compare_out_a: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    ctrl_q.module_enable |=> waveform_out_o ==
    (($past(cnt_q) >= $past(duty_act_q)) ^ $past(ctrl_q.output_invert)))
    else $error("waveform compare wrong");

  duty_stable_a: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    !reload |=> $stable(duty_act_q))
    else $error("active duty changed mid cycle");

  staged_commit_a: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    !(req.wr && req.addr == PERIOD_HIGH_ADDR) |=>
    $stable(period_q) && $stable(duty_sh_q))
    else $error("commit without period high write");

  // commit copies the staged bytes, not the bus byte of another address
  commit_values_a: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (req.wr && req.addr == PERIOD_HIGH_ADDR) |=>
    period_q == {$past(wdata_i), $past(per_lo_tmp_q)} &&
    duty_sh_q == {$past(duty_hi_tmp_q), $past(duty_lo_tmp_q)})
    else $error("commit values wrong");

  // shadow duty reaches the comparator at the reload edge
  duty_load_a: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    reload |=> duty_act_q == $past(duty_sh_q))
    else $error("active duty not loaded at reload");

  // counter steps by exactly one between reloads
  counter_step_a: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (tick && !reload) |=> cnt_q == $past(cnt_q) + 16'h0001)
    else $error("counter did not advance by one");

  // with a nonzero prescale two ticks never come back to back
  tick_spacing_a: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (tick && ctrl_q.prescale_select != PRESCALE_RESET &&
     !(req.wr && req.addr == WAVEFORM_CONTROL_ADDR)) |=> !tick)
    else $error("prescaled ticks too close");

  // inverted polarity written in its own form, high below duty
  invert_out_a: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (ctrl_q.module_enable && ctrl_q.output_invert) |=>
    waveform_out_o == ($past(cnt_q) < $past(duty_act_q)))
    else $error("inverted output wrong");

  ////////////////////////////////////////////////////////////////////////
  // read port checks
  read_idle_a: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    !req.rd |=> rdata_o == BYTE_RESET)
    else $error("read data not zero after idle cycle");

  read_period_a: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (req.rd && req.addr == PERIOD_HIGH_ADDR) |=>
    rdata_o == ($past(period_q) >> 8))
    else $error("period high read wrong");

  read_flag_a: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (req.rd && req.addr == WAVEFORM_CONTROL_ADDR) |=>
    rdata_o[RELOAD_FLAG_BIT] == $past(flag_q))
    else $error("flag read wrong");

endmodule // pwm16

// *** verif/pwm16_test.sv ***
// self-checking bench for the 16-bit pwm block: registers, waveform, flag
`timescale 1ns/100ps
module pwm16_test;
  import pwm16_pkg::*;
  logic clk_sys_i;
  logic rst_n_i;
  logic [15:0] addr_i;
  logic [7:0] wdata_i;
  logic wr_i;
  logic rd_i;
  logic [7:0] rdata_o;
  logic waveform_out_o;
  logic shared_irq_line_o;
  int errors;
  int comparisons;
  logic [7:0] rv;

  pwm16 dut_u (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .waveform_out_o(waveform_out_o), .shared_irq_line_o(shared_irq_line_o));

  ////////////////////////////////////////////////////////////////////////
  // clock and watchdog
  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  initial begin
    #200000;
    errors++;
    wrap_up();
  end

  ////////////////////////////////////////////////////////////////////////
  // bus tasks and compare
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge clk_sys_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask
  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // count high output cycles over a window of n clocks
  task automatic high_count(input int n, output logic [7:0] h);
    h = 8'h00;
    repeat (n) begin
      @(posedge clk_sys_i);
      #1 if (waveform_out_o === 1'b1) h = h + 8'h01;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset();
    rd(WAVEFORM_CONTROL_ADDR, rv);
    chk("ctrl", 8'h00, rv);
    rd(PERIOD_HIGH_ADDR, rv);
    chk("per_hi", 8'h00, rv);
    rd(PERIOD_LOW_ADDR, rv);
    chk("per_lo", 8'h00, rv);
    rd(DUTY_HIGH_ADDR, rv);
    chk("duty_hi", 8'h00, rv);
    rd(DUTY_LOW_ADDR, rv);
    chk("duty_lo", 8'h00, rv);
    rd(16'hA02D, rv);
    chk("unmapped", 8'h00, rv);
  endtask
  // period 3, prescale 1: 8 clocks a cycle, duty 1 gives 3 of 4 ticks high
  task automatic t_wave();
    wr(PERIOD_LOW_ADDR, 8'h03);
    wr(DUTY_HIGH_ADDR, 8'h00);
    wr(DUTY_LOW_ADDR, 8'h01);
    rd(PERIOD_LOW_ADDR, rv);
    chk("per_lo tmp", 8'h03, rv);
    wr(PERIOD_HIGH_ADDR, 8'h00);
    wr(WAVEFORM_CONTROL_ADDR, 8'h90);
    repeat (20) @(posedge clk_sys_i);
    high_count(16, rv);
    chk("high clk", 8'h0C, rv);
    wr(WAVEFORM_CONTROL_ADDR, 8'h92);
    repeat (10) @(posedge clk_sys_i);
    high_count(16, rv);
    chk("inv high", 8'h04, rv);
    // staged duty must not act before the period high write
    wr(DUTY_LOW_ADDR, 8'h03);
    repeat (10) @(posedge clk_sys_i);
    high_count(16, rv);
    chk("staged", 8'h04, rv);
    wr(PERIOD_HIGH_ADDR, 8'h00);
    repeat (10) @(posedge clk_sys_i);
    high_count(16, rv);
    chk("commit", 8'h0C, rv);
  endtask
  task automatic t_flag();
    rd(WAVEFORM_CONTROL_ADDR, rv);
    chk("flag set", 8'h93, rv);
    chk("irq off", 8'h00, {7'h00, shared_irq_line_o});
    wr(WAVEFORM_CONTROL_ADDR, 8'h94);
    repeat (4) @(posedge clk_sys_i);
    #1 chk("irq on", 8'h01, {7'h00, shared_irq_line_o});
    wr(WAVEFORM_CONTROL_ADDR, 8'h0C);
    repeat (3) @(posedge clk_sys_i);
    #1 chk("idle hi", 8'h01, {7'h00, waveform_out_o});
    rd(WAVEFORM_CONTROL_ADDR, rv);
    chk("w0 keeps", 8'h0D, rv);
    wr(WAVEFORM_CONTROL_ADDR, 8'h0D);
    rd(WAVEFORM_CONTROL_ADDR, rv);
    chk("w1 clears", 8'h0C, rv);
    chk("irq clr", 8'h00, {7'h00, shared_irq_line_o});
    repeat (20) @(posedge clk_sys_i);
    #1 chk("held", 8'h01, {7'h00, waveform_out_o});
    wr(WAVEFORM_CONTROL_ADDR, 8'h00);
    repeat (3) @(posedge clk_sys_i);
    #1 chk("idle lo", 8'h00, {7'h00, waveform_out_o});
  endtask

  ////////////////////////////////////////////////////////////////////////
  // verdict and main sequence
  task automatic wrap_up();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    errors = 0;
    comparisons = 0;
    rst_n_i = 1'b0;
    addr_i = 16'h0000;
    wdata_i = 8'h00;
    wr_i = 1'b0;
    rd_i = 1'b0;
    repeat (4) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    t_reset();
    t_wave();
    t_flag();
    wrap_up();
  end
endmodule // pwm16_test
